// ---- hw/nes_pkg.sv ----
// Constants, types and encodings of the NOR erase sequencer host.
// Function
// - Host loads consecutive words from offset zero.
// - On error flag, reread polling flag before failing.
// - Reset after failure, abort-reset after abort.
// - Chip erase is six writes, 80h then 10h.
// - Bypass chip erase needs only two writes.
// - Block erase six writes; repeat sixth per block.
// - Bypass block erase two writes; repeat second per block.
// - Resume 30h only in read array mode; repeatable.
package nes_pkg;

   // ---------------------------------------------------------------
   // Clock and bus timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_WP_NS       = 45;
   localparam int T_WPH_NS      = 30;
   localparam int T_ACC_NS      = 70;
   localparam logic [2:0] WP_CYC  =
      3'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] WPH_CYC =
      3'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] ACC_CYC =
      3'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int DQ_W   = 16;
   localparam int IDX_W  = 8;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_POLL    = 8;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_DONE    = 1;
   localparam int STAT_FAIL    = 2;
   localparam int STAT_ABORT   = 3;
   localparam int STAT_IDX_LSB = 8;
   localparam int STAT_DQ_LSB  = 16;

   // ---------------------------------------------------------------
   // Status word bits on the data lines
   // ---------------------------------------------------------------
   localparam int ABORT_FLAG_BIT   = 1;
   localparam int ERROR_FLAG_BIT   = 5;
   localparam int TOGGLE_FLAG_BIT  = 6;
   localparam int POLLING_FLAG_BIT = 7;

   // ---------------------------------------------------------------
   // Command codes and unlock addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_UNLOCK1  = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2  = 8'h55;
   localparam logic [7:0] CMD_ERASE    = 8'h80;
   localparam logic [7:0] CMD_CHIP     = 8'h10;
   localparam logic [7:0] CMD_BLOCK    = 8'h30;
   localparam logic [7:0] CMD_SUSPEND  = 8'hB0;
   localparam logic [7:0] CMD_RESUME   = 8'h30;
   localparam logic [7:0] CMD_RESET    = 8'hF0;
   localparam logic [7:0] CMD_EXIT1    = 8'h90;
   localparam logic [7:0] CMD_EXIT2    = 8'h00;
   localparam logic [7:0] CMD_ENH_SET  = 8'h33;
   localparam logic [7:0] CMD_ENH_CONF = 8'h29;
   localparam logic [ADDR_W-1:0] ADDR_U1 = 24'h000555;
   localparam logic [ADDR_W-1:0] ADDR_U2 = 24'h0002AA;
   localparam logic [ADDR_W-1:0] ADDR_X  = 24'h000000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE      = 4'h0,
      OP_CHIP      = 4'h1,
      OP_BLOCK     = 4'h2,
      OP_BLK_ADD   = 4'h3,
      OP_UB_CHIP   = 4'h4,
      OP_UB_BLOCK  = 4'h5,
      OP_SUSPEND   = 4'h6,
      OP_RESUME    = 4'h7,
      OP_RESET     = 4'h8,
      OP_ABORT_RST = 4'h9,
      OP_EXIT_ENH  = 4'hA,
      OP_ENH_SET   = 4'hB,
      OP_ENH_LOAD  = 4'hC,
      OP_ENH_CONF  = 4'hD,
      OP_POLL      = 4'hE
   } nes_op_e;

   typedef enum logic [2:0] {
      SEL_U1   = 3'h0,
      SEL_U2   = 3'h1,
      SEL_BLK  = 3'h2,
      SEL_X    = 3'h3,
      SEL_LOAD = 3'h4
   } nes_sel_e;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_WSET   = 6'h02,
      ST_WPULSE = 6'h04,
      ST_WREC   = 6'h08,
      ST_RPULSE = 6'h10,
      ST_EVAL   = 6'h20
   } nes_state_e;

   typedef struct packed {
      nes_sel_e   sel;
      logic [7:0] code;
      logic       last;
   } nes_step_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   dq;
      logic              dq_oe_n;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
   } nes_pins_s;

endpackage : nes_pkg

// ---- hw/nes_host_ctrl.sv ----
// Host controller that issues erase and buffer commands to a NOR flash.
`timescale 1ns/1ps
`default_nettype none
module nes_host_ctrl (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // Wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [31:0]                wb_adr_i,
   input  wire logic [31:0]                wb_dat_i,
   input  wire logic [3:0]                 wb_sel_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // Flash pins
   output nes_pkg::nes_pins_s              flash_o,
   input  wire logic [nes_pkg::DQ_W-1:0]   flash_dq_i
);

   // ---------------------------------------------------------------
   // Command sequences
   // ---------------------------------------------------------------
   function automatic nes_pkg::nes_step_s seq(input nes_pkg::nes_op_e op,
                                              input logic [2:0] st);
      nes_pkg::nes_step_s s;
      s = '{nes_pkg::SEL_X, nes_pkg::CMD_RESET, 1'b1};
      case (op)
         nes_pkg::OP_CHIP, nes_pkg::OP_BLOCK: begin
            case (st)
               3'h0: s = '{nes_pkg::SEL_U1, nes_pkg::CMD_UNLOCK1, 1'b0};
               3'h1: s = '{nes_pkg::SEL_U2, nes_pkg::CMD_UNLOCK2, 1'b0};
               3'h2: s = '{nes_pkg::SEL_U1, nes_pkg::CMD_ERASE, 1'b0};
               3'h3: s = '{nes_pkg::SEL_U1, nes_pkg::CMD_UNLOCK1, 1'b0};
               3'h4: s = '{nes_pkg::SEL_U2, nes_pkg::CMD_UNLOCK2, 1'b0};
               default: begin
                  if (op == nes_pkg::OP_CHIP) begin
                     s = '{nes_pkg::SEL_U1, nes_pkg::CMD_CHIP, 1'b1};
                  end else begin
                     s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_BLOCK, 1'b1};
                  end
               end
            endcase
         end
         nes_pkg::OP_BLK_ADD: begin
            s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_BLOCK, 1'b1};
         end
         nes_pkg::OP_UB_CHIP: begin
            if (st == 3'h0) begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_ERASE, 1'b0};
            end else begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_CHIP, 1'b1};
            end
         end
         nes_pkg::OP_UB_BLOCK: begin
            if (st == 3'h0) begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_ERASE, 1'b0};
            end else begin
               s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_BLOCK, 1'b1};
            end
         end
         nes_pkg::OP_SUSPEND: begin
            s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_SUSPEND, 1'b1};
         end
         nes_pkg::OP_RESUME: begin
            if (st == 3'h0) begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_RESET, 1'b0};
            end else begin
               s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_RESUME, 1'b1};
            end
         end
         nes_pkg::OP_ABORT_RST: begin
            case (st)
               3'h0: s = '{nes_pkg::SEL_U1, nes_pkg::CMD_UNLOCK1, 1'b0};
               3'h1: s = '{nes_pkg::SEL_U2, nes_pkg::CMD_UNLOCK2, 1'b0};
               default: s = '{nes_pkg::SEL_U1, nes_pkg::CMD_RESET, 1'b1};
            endcase
         end
         nes_pkg::OP_EXIT_ENH: begin
            if (st == 3'h0) begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_EXIT1, 1'b0};
            end else begin
               s = '{nes_pkg::SEL_X, nes_pkg::CMD_EXIT2, 1'b1};
            end
         end
         nes_pkg::OP_ENH_SET: begin
            s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_ENH_SET, 1'b1};
         end
         nes_pkg::OP_ENH_LOAD: begin
            s = '{nes_pkg::SEL_LOAD, 8'h00, 1'b1};
         end
         nes_pkg::OP_ENH_CONF: begin
            s = '{nes_pkg::SEL_BLK, nes_pkg::CMD_ENH_CONF, 1'b1};
         end
         default: begin
            s = '{nes_pkg::SEL_X, nes_pkg::CMD_RESET, 1'b1};
         end
      endcase
      return s;
   endfunction : seq

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   nes_pkg::nes_state_e             state_r,  state_nxt;
   nes_pkg::nes_op_e                op_r,     op_nxt;
   logic [2:0]                      step_r,   step_nxt;
   logic [2:0]                      tmr_r,    tmr_nxt;
   logic [1:0]                      rdn_r,    rdn_nxt;
   logic                            poll_r,   poll_nxt;
   logic                            done_r,   done_nxt;
   logic                            fail_r,   fail_nxt;
   logic                            abort_r,  abort_nxt;
   logic [nes_pkg::IDX_W-1:0]       idx_r,    idx_nxt;
   logic [nes_pkg::ADDR_W-1:0]      blk_r,    blk_nxt;
   logic [nes_pkg::DQ_W-1:0]        wdat_r,   wdat_nxt;
   logic [nes_pkg::DQ_W-1:0]        prev_r,   prev_nxt;
   nes_pkg::nes_pins_s              pins_r,   pins_nxt;
   logic                            ack_r,    ack_nxt;
   logic [31:0]                     rdat_r,   rdat_nxt;
   nes_pkg::nes_step_s              cur;
   logic [31:0]                     mask;
   logic                            wr_acc;
   logic [7:0]                      reg_off;

   assign cur     = seq(op_r, step_r);
   assign reg_off = wb_adr_i[7:0];
   assign wr_acc  = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
   assign mask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // ---------------------------------------------------------------
   // Next values
   // ---------------------------------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic [31:0] ctl;
      wv        = wb_dat_i & mask;
      ctl       = wv;
      state_nxt = state_r;
      op_nxt    = op_r;
      step_nxt  = step_r;
      tmr_nxt   = tmr_r;
      rdn_nxt   = rdn_r;
      poll_nxt  = poll_r;
      done_nxt  = done_r;
      fail_nxt  = fail_r;
      abort_nxt = abort_r;
      idx_nxt   = idx_r;
      blk_nxt   = blk_r;
      wdat_nxt  = wdat_r;
      prev_nxt  = prev_r;
      pins_nxt  = pins_r;
      ack_nxt   = wb_cyc_i & wb_stb_i & ~ack_r;
      rdat_nxt  = 32'h0000_0000;
      // Read data stands only with the acknowledge of a read.
      if (ack_nxt && !wb_we_i) begin
         case (reg_off)
            nes_pkg::REG_ADDR:   rdat_nxt = 32'(blk_r);
            nes_pkg::REG_WDATA:  rdat_nxt = 32'(wdat_r);
            nes_pkg::REG_STATUS: begin
               rdat_nxt[nes_pkg::STAT_BUSY]  = (state_r != nes_pkg::ST_IDLE);
               rdat_nxt[nes_pkg::STAT_DONE]  = done_r;
               rdat_nxt[nes_pkg::STAT_FAIL]  = fail_r;
               rdat_nxt[nes_pkg::STAT_ABORT] = abort_r;
               rdat_nxt[nes_pkg::STAT_IDX_LSB +: nes_pkg::IDX_W] = idx_r;
               rdat_nxt[nes_pkg::STAT_DQ_LSB +: nes_pkg::DQ_W]   = prev_r;
            end
            default: rdat_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_acc && state_r == nes_pkg::ST_IDLE) begin
         if (reg_off == nes_pkg::REG_ADDR) begin
            blk_nxt = nes_pkg::ADDR_W'((32'(blk_r) & ~mask) | wv);
         end
         if (reg_off == nes_pkg::REG_WDATA) begin
            wdat_nxt = nes_pkg::DQ_W'((32'(wdat_r) & ~mask) | wv);
         end
         if (reg_off == nes_pkg::REG_CTRL && wb_sel_i[0]) begin
            op_nxt    = nes_pkg::nes_op_e'(ctl[nes_pkg::CTRL_OP_LSB +: 4]);
            poll_nxt  = ctl[nes_pkg::CTRL_POLL];
            step_nxt  = 3'h0;
            rdn_nxt   = 2'h0;
            done_nxt  = 1'b0;
            fail_nxt  = 1'b0;
            abort_nxt = 1'b0;
            if (op_nxt == nes_pkg::OP_POLL) begin
               state_nxt = nes_pkg::ST_RPULSE;
               tmr_nxt   = nes_pkg::ACC_CYC;
               pins_nxt  = '{blk_r, '0, 1'b1, 1'b0, 1'b0, 1'b1};
            end else if (op_nxt != nes_pkg::OP_NONE) begin
               state_nxt = nes_pkg::ST_WSET;
            end
         end
      end
      case (state_r)
         nes_pkg::ST_IDLE: begin
            if (state_nxt == nes_pkg::ST_IDLE) begin
               pins_nxt.ce_n    = 1'b1;
               pins_nxt.oe_n    = 1'b1;
               pins_nxt.we_n    = 1'b1;
               pins_nxt.dq_oe_n = 1'b1;
            end
         end
         nes_pkg::ST_WSET: begin
            case (cur.sel)
               nes_pkg::SEL_U1:  pins_nxt.addr = nes_pkg::ADDR_U1;
               nes_pkg::SEL_U2:  pins_nxt.addr = nes_pkg::ADDR_U2;
               nes_pkg::SEL_BLK: pins_nxt.addr = blk_r;
               nes_pkg::SEL_LOAD: begin
                  pins_nxt.addr = {blk_r[nes_pkg::ADDR_W-1:nes_pkg::IDX_W],
                                   idx_r};
               end
               default:          pins_nxt.addr = nes_pkg::ADDR_X;
            endcase
            pins_nxt.dq      = (cur.sel == nes_pkg::SEL_LOAD) ? wdat_r
                               : nes_pkg::DQ_W'(cur.code);
            pins_nxt.dq_oe_n = 1'b0;
            pins_nxt.ce_n    = 1'b0;
            pins_nxt.oe_n    = 1'b1;
            pins_nxt.we_n    = 1'b0;
            tmr_nxt          = nes_pkg::WP_CYC;
            state_nxt        = nes_pkg::ST_WPULSE;
         end
         nes_pkg::ST_WPULSE: begin
            tmr_nxt = tmr_r - 3'h1;
            if (tmr_r == 3'h1) begin
               pins_nxt.we_n = 1'b1;
               tmr_nxt       = nes_pkg::WPH_CYC;
               state_nxt     = nes_pkg::ST_WREC;
            end
         end
         nes_pkg::ST_WREC: begin
            tmr_nxt = tmr_r - 3'h1;
            if (tmr_r == 3'h1) begin
               pins_nxt.ce_n    = 1'b1;
               pins_nxt.dq_oe_n = 1'b1;
               if (!cur.last) begin
                  step_nxt  = step_r + 3'h1;
                  state_nxt = nes_pkg::ST_WSET;
               end else begin
                  if (op_r == nes_pkg::OP_ENH_SET) begin
                     idx_nxt = '0;
                  end
                  if (op_r == nes_pkg::OP_ENH_LOAD) begin
                     idx_nxt = idx_r + 8'h01;
                  end
                  if (poll_r) begin
                     // Chip enable stays high one cycle before polling.
                     rdn_nxt   = 2'h3;
                     state_nxt = nes_pkg::ST_EVAL;
                  end else begin
                     done_nxt  = 1'b1;
                     state_nxt = nes_pkg::ST_IDLE;
                  end
               end
            end
         end
         nes_pkg::ST_RPULSE: begin
            tmr_nxt = tmr_r - 3'h1;
            if (tmr_r == 3'h1) begin
               pins_nxt.oe_n = 1'b1;
               pins_nxt.ce_n = 1'b1;
               state_nxt     = nes_pkg::ST_EVAL;
            end
         end
         nes_pkg::ST_EVAL: begin
            prev_nxt  = flash_dq_i;
            pins_nxt  = '{blk_r, '0, 1'b1, 1'b0, 1'b0, 1'b1};
            tmr_nxt   = nes_pkg::ACC_CYC;
            state_nxt = nes_pkg::ST_RPULSE;
            rdn_nxt   = (rdn_r == 2'h3) ? 2'h0 : 2'h1;
            if (rdn_r == 2'h2) begin
               pins_nxt  = pins_r;
               poll_nxt  = 1'b0;
               step_nxt  = 3'h0;
               if (flash_dq_i[nes_pkg::POLLING_FLAG_BIT]) begin
                  done_nxt  = 1'b1;
                  state_nxt = nes_pkg::ST_IDLE;
               end else begin
                  fail_nxt  = 1'b1;
                  op_nxt    = nes_pkg::OP_RESET;
                  state_nxt = nes_pkg::ST_WSET;
               end
            end else if (rdn_r == 2'h1) begin
               if (flash_dq_i[nes_pkg::TOGGLE_FLAG_BIT] ==
                   prev_r[nes_pkg::TOGGLE_FLAG_BIT]) begin
                  pins_nxt  = pins_r;
                  done_nxt  = 1'b1;
                  poll_nxt  = 1'b0;
                  state_nxt = nes_pkg::ST_IDLE;
               end else if (flash_dq_i[nes_pkg::ABORT_FLAG_BIT]) begin
                  pins_nxt  = pins_r;
                  abort_nxt = 1'b1;
                  poll_nxt  = 1'b0;
                  step_nxt  = 3'h0;
                  op_nxt    = nes_pkg::OP_ABORT_RST;
                  state_nxt = nes_pkg::ST_WSET;
               end else if (flash_dq_i[nes_pkg::ERROR_FLAG_BIT]) begin
                  rdn_nxt = 2'h2;
               end
            end
         end
         default: begin
            pins_nxt  = '{nes_pkg::ADDR_X, '0, 1'b1, 1'b1, 1'b1, 1'b1};
            state_nxt = nes_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= nes_pkg::ST_IDLE;
         op_r    <= nes_pkg::OP_NONE;
         step_r  <= 3'h0;
         tmr_r   <= 3'h0;
         rdn_r   <= 2'h0;
         poll_r  <= 1'b0;
         done_r  <= 1'b0;
         fail_r  <= 1'b0;
         abort_r <= 1'b0;
         idx_r   <= '0;
         blk_r   <= '0;
         wdat_r  <= '0;
         prev_r  <= '0;
         pins_r  <= '{nes_pkg::ADDR_X, '0, 1'b1, 1'b1, 1'b1, 1'b1};
         ack_r   <= 1'b0;
         rdat_r  <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         step_r  <= step_nxt;
         tmr_r   <= tmr_nxt;
         rdn_r   <= rdn_nxt;
         poll_r  <= poll_nxt;
         done_r  <= done_nxt;
         fail_r  <= fail_nxt;
         abort_r <= abort_nxt;
         idx_r   <= idx_nxt;
         blk_r   <= blk_nxt;
         wdat_r  <= wdat_nxt;
         prev_r  <= prev_nxt;
         pins_r  <= pins_nxt;
         ack_r   <= ack_nxt;
         rdat_r  <= rdat_nxt;
      end
   end

   assign flash_o  = pins_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

endmodule : nes_host_ctrl
`default_nettype wire

// ---- tb/nes_host_sva.sv ----
// Concurrent checks on the bus and flash pins of the host controller.
`timescale 1ns/1ps
`default_nettype none
module nes_host_sva (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               rst_n,
   // Register bus
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_we_i,
   input wire logic [31:0]        wb_adr_i,
   input wire logic [31:0]        wb_dat_i,
   input wire logic [3:0]         wb_sel_i,
   input wire logic [31:0]        wb_dat_o,
   input wire logic               wb_ack_o,
   // Flash pins
   input wire nes_pkg::nes_pins_s flash_o,
   input wire logic [15:0]        flash_dq_i
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_wlow;
      !flash_o.we_n ##1 flash_o.we_n;
   endsequence
   sequence s_ce_hold;
      !flash_o.ce_n [*2] ##1 flash_o.ce_n;
   endsequence
   sequence s_rd;
      !flash_o.oe_n [*3] ##1 flash_o.oe_n;
   endsequence
   chk_ack_next: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_ack_once: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_dat_idle: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
   chk_we_pulse: assert property (
      $fell(flash_o.we_n) |=> s_wlow) else $error("write pulse length");
   chk_ce_hold: assert property (
      $rose(flash_o.we_n) |-> s_ce_hold) else $error("write recovery");
   chk_we_framed: assert property (
      !flash_o.we_n |-> !flash_o.ce_n && !flash_o.dq_oe_n)
      else $error("write outside select");
   chk_read_len: assert property (
      $fell(flash_o.oe_n) |-> s_rd) else $error("read length");
   chk_no_fight: assert property (
      !flash_o.oe_n |-> flash_o.we_n && flash_o.dq_oe_n)
      else $error("bus contention");
endmodule : nes_host_sva
bind nes_host_ctrl nes_host_sva u_sva (
   .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .flash_o(flash_o), .flash_dq_i(flash_dq_i));
`default_nettype wire

// ---- tb/nes_flash_model.sv ----
// Behavioural model of the flash device facing the host controller.
`timescale 1ns/1ps
`default_nettype none
module nes_flash_model (
   // Flash pins
   input  wire nes_pkg::nes_pins_s pins,
   output logic [15:0]             dq_o,
   // Scenario controls
   input  wire logic               abort_en,
   input  wire logic               fail_en,
   input  wire logic [7:0]         busy_reads
);
   logic [7:0] prev = 8'h0, c, busy = 8'h0;
   logic       tog = 1'b0, aborted = 1'b0, failed = 1'b0;
   logic       enh = 1'b0, chip = 1'b0;
   initial dq_o = 16'hFFFF;
   // Commands are taken on the rising write strobe; loads are not decoded.
   always @(posedge pins.we_n) begin
      if (pins.ce_n === 1'b0 && pins.dq[15:8] === 8'h0) begin
         c = pins.dq[7:0];
         if (aborted) begin
            aborted = (c != 8'hF0);
         end else if (enh) begin
            enh = !(prev == 8'h90 && c == 8'h00);
            aborted = (c == 8'h29 && abort_en);
         end else if (!(busy > 0 && chip)) begin
            enh = (c == 8'h33);
            failed = failed && (c != 8'hF0);
            if (c == 8'hB0) busy = 8'h0;
            if (prev inside {8'h55, 8'h80} && c == 8'h10) begin
               chip = 1'b1;
               busy = busy_reads;
            end
            if (prev inside {8'h55, 8'h80, 8'h30, 8'hF0} && c == 8'h30) begin
               chip = 1'b0;
               busy = busy_reads;
            end
            if (c inside {8'h10, 8'h30}) tog = 1'b0;
         end
         prev = c;
      end
   end
   // A read starts when output enable falls; busy or error reads give status.
   always @(negedge pins.oe_n) begin
      if (pins.ce_n === 1'b0) begin
         dq_o = 16'hFFFF;
         if (busy > 0 || failed || aborted) begin
            tog = ~tog;
            dq_o = 16'h0;
            dq_o[nes_pkg::TOGGLE_FLAG_BIT] = tog;
            dq_o[nes_pkg::ABORT_FLAG_BIT] = aborted;
            dq_o[nes_pkg::ERROR_FLAG_BIT] = failed;
         end
         if (busy > 0) begin
            busy = busy - 8'h1;
            failed = (busy == 8'h0) && chip && fail_en;
         end
      end
   end
   // Released lines stop showing the last word once the hold time ends.
   always @(posedge pins.oe_n) begin
      #30;
      if (pins.oe_n) dq_o = ~dq_o;
   end
endmodule : nes_flash_model
`default_nettype wire

// ---- tb/nes_host_ctrl_bench.sv ----
// Self-checking bench for the NOR erase sequencer host.
`timescale 1ns/1ps
`default_nettype none
module nes_host_ctrl_bench;
   logic               ref_clk = 1'b0, rst_n = 1'b0, ack;
   logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic               abort_en = 1'b0, fail_en = 1'b0;
   logic [7:0]         busy_reads = 8'h05;
   logic [31:0]        adr = 32'h0, wdat = 32'h0, dato, rdat;
   logic [15:0]        dq;
   logic [23:0]        blk = 24'h0;
   logic [3:0]         ops [4] = '{4'h1, 4'h4, 4'h2, 4'h5};
   nes_pkg::nes_pins_s pins;
   int                 n_mismatch = 0, tests_run = 0, seed = 86;

   always #12.5 ref_clk = ~ref_clk;

   nes_host_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_dat_o(dato), .wb_ack_o(ack), .flash_o(pins),
      .flash_dq_i(dq));
   nes_flash_model u_flash (.pins(pins), .dq_o(dq), .abort_en(abort_en),
      .fail_en(fail_en), .busy_reads(busy_reads));

   function automatic logic [31:0] exp_st(input logic [15:0] w,
                                          input logic [3:0] f);
      return {w, 12'h0, f};
   endfunction : exp_st

   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int i;
      i = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h0, a};
      wdat <= d;
      do begin
         @(posedge ref_clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      rdat = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 50) begin
         n_mismatch++;
         end_of_test();
      end
      @(posedge ref_clk);
   endtask : wb

   task automatic run(input logic [3:0] op, input logic p);
      int i;
      i = 0;
      wb(1'b1, nes_pkg::REG_ADDR, {8'h0, blk});
      wb(1'b1, nes_pkg::REG_CTRL, {23'h0, p, 4'h0, op});
      do begin
         wb(1'b0, nes_pkg::REG_STATUS, 32'h0);
         i++;
      end while (rdat[nes_pkg::STAT_BUSY] !== 1'b0 && i < 2000);
      if (i >= 2000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : run

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      check({28'h0, pins.dq_oe_n, pins.ce_n, pins.oe_n, pins.we_n}, 32'hF,
            "idle pins");
      wb(1'b0, nes_pkg::REG_STATUS, 32'h0);
      check(rdat, exp_st(16'h0, 4'h0), "status reset");
      wb(1'b1, 8'h10, 32'($random(seed)));
      wb(1'b0, 8'h10, 32'h0);
      check(rdat, 32'h0, "unmapped");
      foreach (ops[k]) begin
         blk = 24'($random(seed));
         busy_reads <= k[0] ? 8'h09 : 8'h05;
         run(ops[k], 1'b1);
         check(rdat, exp_st(16'hFFFF, 4'h2), "erase");
      end
      run(4'h2, 1'b0);
      blk = blk ^ 24'h010000;
      run(4'h3, 1'b1);
      check(rdat, exp_st(16'hFFFF, 4'h2), "add block");
      fail_en <= 1'b1;
      run(4'h1, 1'b1);
      check(rdat & 32'h4, 32'h4, "failed");
      fail_en <= 1'b0;
      run(4'hE, 1'b1);
      check(rdat, exp_st(16'hFFFF, 4'h2), "error cleared");
      run(4'h2, 1'b0);
      repeat (2) begin
         run(4'h6, 1'b0);
         run(4'h7, 1'b0);
      end
      run(4'hE, 1'b1);
      check(rdat, exp_st(16'hFFFF, 4'h2), "resumed");
      abort_en <= 1'b1;
      run(4'hB, 1'b0);
      for (int k = 1; k <= 3; k++) begin
         wb(1'b1, nes_pkg::REG_WDATA, 32'($random(seed)) | 32'h8000);
         run(4'hC, 1'b0);
         check(32'(rdat[15:8]), 32'(k), "load index");
      end
      run(4'hD, 1'b0);
      run(4'hE, 1'b1);
      check(rdat & 32'h8, 32'h8, "aborted");
      abort_en <= 1'b0;
      run(4'hA, 1'b0);
      run(4'h1, 1'b1);
      check(rdat & 32'hFFFF00FF, exp_st(16'hFFFF, 4'h2), "exit");
      end_of_test();
   end
endmodule : nes_host_ctrl_bench
`default_nettype wire
